//--- verilog/rtc_regs.vh
// Register offsets, field positions, reset values and timing counts of the RTC core.
// Assumes inclusion by bare name from the core module; definitions only.
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// Register offsets on the multiplexed bus
`define RTC_OFF_SEC 8'h00
`define RTC_OFF_AL_S 8'h01
`define RTC_OFF_MIN 8'h02
`define RTC_OFF_AL_M 8'h03
`define RTC_OFF_HR 8'h04
`define RTC_OFF_AL_H 8'h05
`define RTC_OFF_WDAY 8'h06
`define RTC_OFF_MDAY 8'h07
`define RTC_OFF_MON 8'h08
`define RTC_OFF_YEAR 8'h09
`define RTC_OFF_CTL_A 8'h0A
`define RTC_OFF_CTL_B 8'h0B
`define RTC_OFF_CTL_C 8'h0C
`define RTC_OFF_CTL_D 8'h0D
`define RTC_OFF_CENT 8'h48
`define RTC_OFF_AL_D 8'h49

// Control register A and B fields
`define RTC_A_UIP 7
`define RTC_A_OSC_HI 6
`define RTC_A_OSC_LO 5
`define RTC_A_BANK 4
`define RTC_OSC_RUN 2'b01
`define RTC_OSC_CHAIN_RST 2'b11
`define RTC_B_SET 7
`define RTC_B_AIE 5
`define RTC_B_DM 2
`define RTC_B_H24 1

// Reset and fixed read values
`define RTC_A_RST 7'h20
`define RTC_B_RST 8'h02
`define RTC_C_VAL 8'h00
`define RTC_D_VAL 8'h80
`define RTC_TIME_RST 64'h0000010101000000
`define RTC_ALARM_RST 8'h00
`define RTC_UNMAPPED 8'h00
`define RTC_DC_CODE 2'b11

// Field limits, binary and BCD
`define RTC_SEC_TOP_BIN 8'h3B
`define RTC_SEC_TOP_BCD 8'h59
`define RTC_H24_TOP_BIN 8'h17
`define RTC_H24_TOP_BCD 8'h23
`define RTC_H12_TOP_BIN 8'h0C
`define RTC_H12_TOP_BCD 8'h12
`define RTC_WDAY_TOP 8'h07
`define RTC_MON_TOP_BIN 8'h0C
`define RTC_MON_TOP_BCD 8'h12
`define RTC_YEAR_TOP_BIN 8'h63
`define RTC_YEAR_TOP_BCD 8'h99

// Timing
`define RTC_PRESC_LAST 15'h7FFF
`define RTC_UIP_START 15'h7FF8
`define RTC_CLK_MHZ 100
`define RTC_TREC_US 200
`define RTC_REC_CYCLES 24'h004E20

`endif

//--- verilog/rtc_core.v
// Timekeeping core: double buffered time/calendar, alarm compare, bus access gating.
// Assumes a host on a multiplexed address/data bus and a 32.768 kHz oscillator pin;
// the bus, oscillator and supply pins are asynchronous to sys_clk and are synchronised here; rst_n is used as is.
`timescale 1ns/1ps
`include "rtc_regs.vh"

module rtc_core #(
  parameter [23:0] REC_CYCLES = `RTC_REC_CYCLES
) (
  input wire sys_clk,
  input wire rst_n,
  input wire ale,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire [7:0] ad_in,
  output wire [7:0] ad_out,
  output wire ad_oe_n,
  input wire osc_in,
  input wire vcc_above_trip,
  input wire vcc_access_ok,
  output wire host_access,
  output wire alarm_event
);

localparam [63:0] TIME_RST = `RTC_TIME_RST;
// Offset of each time entry, index order as stored
localparam [63:0] ENT_OFF = {`RTC_OFF_CENT, `RTC_OFF_YEAR, `RTC_OFF_MON, `RTC_OFF_MDAY,
  `RTC_OFF_WDAY, `RTC_OFF_HR, `RTC_OFF_MIN, `RTC_OFF_SEC};

////////////////////////////////////////////////////////////////////////////////
// Helper functions

// Next value of a counting byte, with decimal carry in BCD
function [7:0] rtc_inc;
  input [7:0] v;
  input bcd;
  begin
    if (bcd && (v[3:0] == 4'h9)) begin
      rtc_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      rtc_inc = v + 8'h01;
    end
  end
endfunction

// Step with wrap: returns {carry, next}
function [8:0] rtc_step;
  input [7:0] v;
  input [7:0] top;
  input [7:0] low;
  input bcd;
  begin
    if (v >= top) begin
      rtc_step = {1'b1, low};
    end else begin
      rtc_step = {1'b0, rtc_inc(v, bcd)};
    end
  end
endfunction

// Field value as plain binary
function [7:0] rtc_bin;
  input [7:0] v;
  input bcd;
  begin
    if (bcd) begin
      rtc_bin = {1'b0, v[7:4], 3'b000} + {3'b000, v[7:4], 1'b0} + {4'h0, v[3:0]};
    end else begin
      rtc_bin = v;
    end
  end
endfunction

// Last day of a month in binary; leap rule is year divisible by four
function [7:0] rtc_last;
  input [7:0] mo;
  input leap;
  begin
    case (mo)
      8'h02: rtc_last = leap ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: rtc_last = 8'h1E;
      default: rtc_last = 8'h1F;
    endcase
  end
endfunction

// Alarm byte with both top bits set matches anything
function rtc_dc;
  input [7:0] v;
  begin
    rtc_dc = (v[7:6] == `RTC_DC_CODE);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detect

reg [14:0] sync1_r;
reg [14:0] sync2_r;
reg [2:0] prev_r;

// Two flops per pin; only the second stage is looked at
always @(posedge sys_clk) begin
  if (!rst_n) begin
    sync1_r <= 15'h0E00; // Idle pin levels, so no false strobe edge follows reset
    sync2_r <= 15'h0E00;
    prev_r <= 3'h2;
  end else begin
    sync1_r <= {vcc_access_ok, vcc_above_trip, osc_in, wr_n, rd_n, cs_n, ale, ad_in};
    sync2_r <= sync1_r;
    prev_r <= {sync2_r[12], sync2_r[11], sync2_r[8]};
  end
end

wire [7:0] ad_q = sync2_r[7:0];
wire ale_q = sync2_r[8];
wire cs_q = sync2_r[9];
wire rd_q = sync2_r[10];
wire wr_q = sync2_r[11];
wire osc_q = sync2_r[12];
wire trip_q = sync2_r[13];
wire ok_q = sync2_r[14];
wire ale_fall = prev_r[0] & ~ale_q;
wire wr_rise = ~prev_r[1] & wr_q;
wire osc_rise = ~prev_r[2] & osc_q;

////////////////////////////////////////////////////////////////////////////////
// Control state, oscillator chain and access gate

reg [6:0] ctl_a_r;
reg [7:0] ctl_b_r;
reg [7:0] al_s_r, al_m_r, al_h_r, al_d_r;
reg [14:0] presc_r;
reg [23:0] rec_cnt_r;
reg acc_r;
reg [7:0] addr_r;
reg [7:0] wdat_r;
reg [7:0] ad_out_r;
reg ad_oe_n_r;
reg alarm_r;
reg [7:0] rdata_nxt;

wire [1:0] osc_mode = ctl_a_r[`RTC_A_OSC_HI:`RTC_A_OSC_LO];
wire osc_run = (osc_mode == `RTC_OSC_RUN);
wire chain_rst = (osc_mode == `RTC_OSC_CHAIN_RST);
wire bank1 = ctl_a_r[`RTC_A_BANK];
wire bcd = ~ctl_b_r[`RTC_B_DM];
wire h24 = ctl_b_r[`RTC_B_H24];
wire freeze = ctl_b_r[`RTC_B_SET];
wire rec_done = (rec_cnt_r == REC_CYCLES);
wire uip = osc_run & (presc_r >= `RTC_UIP_START);
wire sec_tick = osc_run & osc_rise & (presc_r == `RTC_PRESC_LAST);
wire wr_go = acc_r & wr_rise & ~cs_q;
wire rd_act = acc_r & ~rd_q & ~cs_q;

// Countdown chain; held at zero in chain reset, frozen with oscillator off
always @(posedge sys_clk) begin
  if (!rst_n || chain_rst) begin
    presc_r <= 15'h0000;
  end else if (osc_run && osc_rise) begin
    presc_r <= presc_r + 15'h0001;
  end
end

// Recovery delay restarts whenever supply drops below the trip point
always @(posedge sys_clk) begin
  if (!rst_n || !trip_q) begin
    rec_cnt_r <= 24'h000000;
  end else if (!rec_done) begin
    rec_cnt_r <= rec_cnt_r + 24'h000001;
  end
end

// Access needs trip point, variant threshold, recovery and a running chain
always @(posedge sys_clk) begin
  if (!rst_n) begin
    acc_r <= 1'b0;
  end else begin
    acc_r <= trip_q & ok_q & rec_done & osc_run;
  end
end

// Address taken on the falling edge of ALE, even without chip select
always @(posedge sys_clk) begin
  if (!rst_n) begin
    addr_r <= 8'h00;
    wdat_r <= 8'h00;
  end else begin
    if (ale_fall) begin
      addr_r <= ad_q;
    end
    if (!wr_q) begin
      wdat_r <= ad_q; // Last value before WR rises is the one written
    end
  end
end

// Control and alarm registers; writes only when access is granted
always @(posedge sys_clk) begin
  if (!rst_n) begin
    ctl_a_r <= `RTC_A_RST;
    ctl_b_r <= `RTC_B_RST;
    al_s_r <= `RTC_ALARM_RST;
    al_m_r <= `RTC_ALARM_RST;
    al_h_r <= `RTC_ALARM_RST;
    al_d_r <= `RTC_ALARM_RST;
  end else if (wr_go) begin
    case (addr_r)
      `RTC_OFF_CTL_A: ctl_a_r <= wdat_r[6:0];
      `RTC_OFF_CTL_B: ctl_b_r <= wdat_r;
      `RTC_OFF_AL_S: al_s_r <= wdat_r;
      `RTC_OFF_AL_M: al_m_r <= wdat_r;
      `RTC_OFF_AL_H: al_h_r <= wdat_r;
      `RTC_OFF_AL_D: begin
        if (bank1) begin
          al_d_r <= wdat_r;
        end
      end
      default: al_s_r <= al_s_r; // C, D and unmapped offsets ignore writes
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Double buffered time entries, one pair per field

wire [63:0] ti_w;
wire [63:0] tu_w;
reg [63:0] time_nxt;

genvar g;
generate
  for (g = 0; g < 8; g = g + 1) begin : ent
    reg [7:0] ti_r;
    reg [7:0] tu_r;
    wire bank_ok = (g != 7) | bank1;
    wire hit = wr_go & bank_ok & (addr_r == ENT_OFF[8*g+:8]);
    wire [7:0] wval = (g == 0) ? {1'b0, wdat_r[6:0]} : wdat_r;
    // A host write lands in both copies so the count resumes from it
    always @(posedge sys_clk) begin
      if (!rst_n) begin
        ti_r <= TIME_RST[8*g+:8];
        tu_r <= TIME_RST[8*g+:8];
      end else if (hit) begin
        ti_r <= wval;
        tu_r <= wval;
      end else if (sec_tick) begin
        ti_r <= time_nxt[8*g+:8];
        if (!freeze) begin
          tu_r <= time_nxt[8*g+:8];
        end
      end
    end
    assign ti_w[8*g+:8] = ti_r;
    assign tu_w[8*g+:8] = tu_r;
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// One-second advance and alarm compare

reg [8:0] s9, m9, h9, w9, d9, o9, y9, c9;
reg [7:0] h12_top;
reg [6:0] hs;
reg [7:0] yb;
reg cm, cd, co, cy;
reg alarm_nxt;

// Carries ripple from seconds up to century in the selected format
always @* begin
  s9 = rtc_step(ti_w[7:0], bcd ? `RTC_SEC_TOP_BCD : `RTC_SEC_TOP_BIN, 8'h00, bcd);
  m9 = rtc_step(ti_w[15:8], bcd ? `RTC_SEC_TOP_BCD : `RTC_SEC_TOP_BIN, 8'h00, bcd);
  h12_top = bcd ? `RTC_H12_TOP_BCD : `RTC_H12_TOP_BIN;
  hs = ti_w[22:16] + 7'h01;
  if (bcd && (ti_w[19:16] == 4'h9)) begin
    hs = {ti_w[22:20] + 3'h1, 4'h0};
  end
  if (h24) begin
    h9 = rtc_step(ti_w[23:16], bcd ? `RTC_H24_TOP_BCD : `RTC_H24_TOP_BIN, 8'h00, bcd);
  end else if (ti_w[22:16] >= h12_top[6:0]) begin
    h9 = {1'b0, ti_w[23], 7'h01};
  end else if (hs == h12_top[6:0]) begin
    h9 = {ti_w[23], ~ti_w[23], hs}; // Day ends at 11 PM to 12 AM
  end else begin
    h9 = {1'b0, ti_w[23], hs};
  end
  w9 = rtc_step(ti_w[31:24], `RTC_WDAY_TOP, 8'h01, bcd);
  yb = rtc_bin(ti_w[55:48], bcd);
  if (rtc_bin(ti_w[39:32], bcd) >= rtc_last(rtc_bin(ti_w[47:40], bcd), yb[1:0] == 2'b00)) begin
    d9 = {1'b1, 8'h01};
  end else begin
    d9 = {1'b0, rtc_inc(ti_w[39:32], bcd)};
  end
  o9 = rtc_step(ti_w[47:40], bcd ? `RTC_MON_TOP_BCD : `RTC_MON_TOP_BIN, 8'h01, bcd);
  y9 = rtc_step(ti_w[55:48], bcd ? `RTC_YEAR_TOP_BCD : `RTC_YEAR_TOP_BIN, 8'h00, bcd);
  c9 = rtc_step(ti_w[63:56], bcd ? `RTC_YEAR_TOP_BCD : `RTC_YEAR_TOP_BIN, 8'h00, bcd);
  cm = s9[8] & m9[8];
  cd = cm & h9[8];
  co = cd & d9[8];
  cy = co & o9[8];
  time_nxt[7:0] = s9[7:0];
  time_nxt[15:8] = s9[8] ? m9[7:0] : ti_w[15:8];
  time_nxt[23:16] = cm ? h9[7:0] : ti_w[23:16];
  time_nxt[31:24] = cd ? w9[7:0] : ti_w[31:24];
  time_nxt[39:32] = cd ? d9[7:0] : ti_w[39:32];
  time_nxt[47:40] = co ? o9[7:0] : ti_w[47:40];
  time_nxt[55:48] = cy ? y9[7:0] : ti_w[55:48];
  time_nxt[63:56] = (cy & y9[8]) ? c9[7:0] : ti_w[63:56];
  // Compare against the time that this update produces
  alarm_nxt = (rtc_dc(al_s_r) | (al_s_r == time_nxt[7:0])) &
              (rtc_dc(al_m_r) | (al_m_r == time_nxt[15:8])) &
              (rtc_dc(al_h_r) | (al_h_r == time_nxt[23:16])) &
              (rtc_dc(al_d_r) | (al_d_r == time_nxt[39:32]));
end

// Alarm pulse once per matching second while enabled
always @(posedge sys_clk) begin
  if (!rst_n) begin
    alarm_r <= 1'b0;
  end else begin
    alarm_r <= sec_tick & ctl_b_r[`RTC_B_AIE] & alarm_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read path; user copy is readable during updates, the century entry only in bank 1

always @* begin
  case (addr_r)
    `RTC_OFF_SEC: rdata_nxt = tu_w[7:0];
    `RTC_OFF_AL_S: rdata_nxt = al_s_r;
    `RTC_OFF_MIN: rdata_nxt = tu_w[15:8];
    `RTC_OFF_AL_M: rdata_nxt = al_m_r;
    `RTC_OFF_HR: rdata_nxt = tu_w[23:16];
    `RTC_OFF_AL_H: rdata_nxt = al_h_r;
    `RTC_OFF_WDAY: rdata_nxt = tu_w[31:24];
    `RTC_OFF_MDAY: rdata_nxt = tu_w[39:32];
    `RTC_OFF_MON: rdata_nxt = tu_w[47:40];
    `RTC_OFF_YEAR: rdata_nxt = tu_w[55:48];
    `RTC_OFF_CTL_A: rdata_nxt = {uip, ctl_a_r};
    `RTC_OFF_CTL_B: rdata_nxt = ctl_b_r;
    `RTC_OFF_CTL_C: rdata_nxt = `RTC_C_VAL;
    `RTC_OFF_CTL_D: rdata_nxt = `RTC_D_VAL;
    `RTC_OFF_CENT: rdata_nxt = bank1 ? tu_w[63:56] : `RTC_UNMAPPED;
    `RTC_OFF_AL_D: rdata_nxt = bank1 ? al_d_r : `RTC_UNMAPPED;
    default: rdata_nxt = `RTC_UNMAPPED;
  endcase
end

// Bus driven only during a granted read; floats otherwise
always @(posedge sys_clk) begin
  if (!rst_n) begin
    ad_out_r <= 8'h00;
    ad_oe_n_r <= 1'b1;
  end else begin
    ad_out_r <= rd_act ? rdata_nxt : 8'h00;
    ad_oe_n_r <= ~rd_act;
  end
end

assign ad_out = ad_out_r;
assign ad_oe_n = ad_oe_n_r;
assign host_access = acc_r;
assign alarm_event = alarm_r;

endmodule

//--- tb/rtc_chk.sv
// Checker for the RTC core: bus drive, supply gating and alarm pulse timing.
// Assumes binding onto rtc_core with the same REC_CYCLES; one clock domain.
`timescale 1ns/1ps
module rtc_chk #(
  parameter [23:0] REC_CYCLES = 24'h000008
) (
  input wire sys_clk,
  input wire rst_n,
  input wire ale,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire [7:0] ad_in,
  input wire [7:0] ad_out,
  input wire ad_oe_n,
  input wire osc_in,
  input wire vcc_above_trip,
  input wire vcc_access_ok,
  input wire host_access,
  input wire alarm_event
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [23:0] up_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles the trip-point pin stayed high; the threshold pin alone does not restart recovery
  always @(posedge sys_clk) begin
    if (!rst_n || !vcc_above_trip) begin
      up_cnt <= 24'h000000;
    end else if (up_cnt != 24'hFFFFFF) begin
      up_cnt <= up_cnt + 24'h000001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Core lags the pin by its synchroniser, so the pin count is an upper bound
  rec_delay_a: assert property ($rose(host_access) |-> up_cnt >= REC_CYCLES)
    else $error("access granted before recovery delay");
  trip_block_a: assert property (!vcc_above_trip [*4] |-> !host_access)
    else $error("access kept below trip point");
  thresh_block_a: assert property (!vcc_access_ok [*4] |-> !host_access)
    else $error("access kept below supply threshold");
  float_no_access_a: assert property (!host_access [*4] |-> ad_oe_n)
    else $error("bus driven without access");
  oe_idle_zero_a: assert property (ad_oe_n |-> ad_out == 8'h00)
    else $error("bus data not zero while floating");
  read_drive_a: assert property ((host_access && !cs_n && !rd_n) [*5] |-> !ad_oe_n)
    else $error("read not answered in time");
  read_release_a: assert property (rd_n [*5] |-> ad_oe_n)
    else $error("bus not released after read");
  alarm_single_a: assert property (alarm_event |=> !alarm_event [*8])
    else $error("alarm pulse repeated");
endmodule

bind rtc_core rtc_chk #(.REC_CYCLES(REC_CYCLES)) i_rtc_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
  .osc_in(osc_in), .vcc_above_trip(vcc_above_trip), .vcc_access_ok(vcc_access_ok),
  .host_access(host_access), .alarm_event(alarm_event)
);

//--- tb/rtc_host.sv
// Host processor model on the multiplexed address/data bus.
// Assumes pins change at the falling clock edge; each ALE and WR strobe level lasts 4 clocks.
`timescale 1ns/1ps
module rtc_host (
  input wire sys_clk,
  input wire [7:0] ad_out,
  input wire ad_oe_n,
  output logic ale,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] ad_in
);
  // Idle bus: strobes inactive
  initial begin
    ale = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ad_in = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic pace(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Address phase, latched by the falling strobe
  task automatic adr(input logic [7:0] a);
    @(negedge sys_clk);
    ad_in = a;
    ale = 1'b1;
    pace(4);
    ale = 1'b0;
    pace(4);
  endtask
  // Data held past the rising write strobe; released bus shows the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adr(a);
    ad_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    pace(4);
    wr_n = 1'b1;
    pace(4);
    cs_n = 1'b1;
    ad_in = ~d;
    pace(2);
  endtask
  // Read waits a bounded time for the core to drive; ok stays 0 if refused
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    adr(a);
    ad_in = ~a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge sys_clk);
      if (ad_oe_n === 1'b0) begin
        ok = 1'b1;
        d = ad_out;
      end
    end
    pace(2);
    rd_n = 1'b1;
    pace(4);
    cs_n = 1'b1;
    pace(2);
  endtask
endmodule

//--- tb/rtc_core_tb_top.sv
// Testbench top for the RTC core: register, power gating and update tests.
// Assumes the host model drives the bus; the oscillator pin is made here.
`timescale 1ns/1ps
module rtc_core_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_in = 1'b0;
  logic osc_run = 1'b0;
  logic vcc_above_trip = 1'b1;
  logic vcc_access_ok = 1'b1;
  logic ale, cs_n, rd_n, wr_n, ad_oe_n, host_access, alarm_event, rd_ok;
  logic [7:0] ad_in, ad_out, rd_val;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_alarm = 0;
  int cyc = 0;
  // Reset values, then time, then post-rollover values
  logic [7:0] ra [12] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h00, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h48, 8'h20};
  logic [7:0] rv [12] = '{8'h20, 8'h02, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] ta [12] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h01, 8'h03, 8'h05, 8'h48, 8'h49};
  logic [7:0] td [12] = '{8'hD9, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h19, 8'h29};
  logic [7:0] pv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h00};
  ////////////////////////////////////////////////////////////////////////////
  rtc_core #(.REC_CYCLES(24'h000008)) i_rtc_core (
    .sys_clk(sys_clk), .rst_n(rst_n), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .osc_in(osc_in),
    .vcc_above_trip(vcc_above_trip), .vcc_access_ok(vcc_access_ok),
    .host_access(host_access), .alarm_event(alarm_event)
  );
  rtc_host i_rtc_host (
    .sys_clk(sys_clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ale(ale),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock, oscillator pin (one rise per two clocks) and alarm pulse counter
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    osc_in <= osc_run ? ~osc_in : 1'b0;
    if (alarm_event === 1'b1) n_alarm++;
  end
  // Hang guard: two seconds of updates plus bus traffic fit well below this
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 200000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_rtc_host.rd(a, rd_val, rd_ok);
    chk(rd_val, exp);
  endtask
  task automatic wait_access();
    for (int i = 0; i < 100 && host_access !== 1'b1; i++) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk({7'h00, host_access}, 8'h00);
    wait_access();
    chk({7'h00, host_access}, 8'h01);
    for (int i = 0; i < 12; i++) rchk(ra[i], rv[i]);
    i_rtc_host.wr(8'h0C, 8'hFF);
    i_rtc_host.wr(8'h0D, 8'h00);
    i_rtc_host.wr(8'h0A, 8'hA0);
    rchk(8'h0C, 8'h00);
    rchk(8'h0D, 8'h80);
    rchk(8'h0A, 8'h20);
    i_rtc_host.wr(8'h48, 8'h55);
    i_rtc_host.wr(8'h0A, 8'h30);
    rchk(8'h48, 8'h00);
    rchk(8'h0B, 8'h02);
    // Each supply flag in turn: writes lost, reads float, access returns
    for (int i = 0; i < 2; i++) begin
      {vcc_above_trip, vcc_access_ok} = i ? 2'b01 : 2'b10;
      repeat (6) @(negedge sys_clk);
      chk({7'h00, host_access}, 8'h00);
      i_rtc_host.wr(8'h02, 8'h33);
      i_rtc_host.rd(8'h02, rd_val, rd_ok);
      chk({7'h00, rd_ok}, 8'h00);
      {vcc_above_trip, vcc_access_ok} = 2'b11;
      wait_access();
      rchk(8'h02, 8'h00);
    end
    // Frozen setup in BCD, 24 h, leap February, hourly alarm with date match
    i_rtc_host.wr(8'h0B, 8'h82);
    for (int i = 0; i < 12; i++) i_rtc_host.wr(ta[i], td[i]);
    rchk(8'h00, 8'h59);
    rchk(8'h49, 8'h29);
    i_rtc_host.wr(8'h0A, 8'h20);
    i_rtc_host.wr(8'h0B, 8'h22);
    osc_run = 1'b1;
    for (int i = 0; i < 70000 && n_alarm == 0; i++) @(negedge sys_clk);
    chk(8'(n_alarm), 8'h01);
    for (int i = 0; i < 7; i++) rchk(ta[i], pv[i]);
    // Freeze across the next second: no alarm at :01, user copy stays put
    i_rtc_host.wr(8'h0B, 8'hA2);
    repeat (65600) @(negedge sys_clk);
    chk(8'(n_alarm), 8'h01);
    rchk(8'h00, 8'h00);
    // Chain held in reset: access is lost until a reset brings the defaults back
    i_rtc_host.wr(8'h0A, 8'h60);
    repeat (4) @(negedge sys_clk);
    chk({7'h00, host_access}, 8'h00);
    i_rtc_host.rd(8'h0A, rd_val, rd_ok);
    chk({7'h00, rd_ok}, 8'h00);
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    wait_access();
    chk({7'h00, host_access}, 8'h01);
    rchk(8'h0A, 8'h20);
    rchk(8'h00, 8'h00);
    end_of_test();
  end
endmodule
